// [rtl/isp_defines.svh]
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH
// Overview of operation
// [R1] second priority register: osc fail bit 7, nvm write bit 4, low voltage bit 2; reset one
// [R2] third priority register: pwm timebase priority at bit 4, one is high, resets one
// [R3] unimplemented priority register bits read zero and ignore writes
// [R4] external pins are edge triggered; select one means rising, zero falling
// [R5] a selected edge sets the pin flag until software writes it clear
// [R6] a cleared pin enable blocks the request while the flag may still set
// [R7] software clears a pin flag before re-enabling, else the request returns
// [R8] an enabled external pin interrupt wakes the core from idle or sleep
// [R9] after wake the core vectors only when the global enable is set
// [R10] pin one, two, three priorities: third reg bits 6 and 7, second reg bit 1
// [R11] external pin zero has no priority bit and is always high priority
// [R12] eight bit timer mode rolling ff to 00 sets the timer flag
// [R13] sixteen bit timer mode sets the flag only on ffff to 0000
// [R14] timer enable at main reg bit 5, priority at second reg bit 2
// [R15] change on the four monitored pins sets pin change flag, main reg bit 0
// [R16] pin change enable at main reg bit 3, priority at second reg bit 0
// [R17] taking an interrupt pushes the return address on the return stack
// [R18] taking an interrupt copies working, status and bank registers into shadow
// [R19] monitored pins compare against value latched at last port read, ored
// [R20] only monitored pins set as inputs take part in the comparison
// [R21] flag and enable both set raise a request at the chosen priority level

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ISP_OFS_MAIN    8'h00
`define ISP_OFS_SECOND  8'h04
`define ISP_OFS_THIRD   8'h08
`define ISP_OFS_PRI2    8'h0c
`define ISP_OFS_PRI3    8'h10
`define ISP_OFS_TZCTL   8'h14
`define ISP_OFS_TZCNT   8'h18
`define ISP_OFS_PDIR    8'h1c
`define ISP_OFS_PORT    8'h20
`define ISP_OFS_PMODE   8'h24

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define ISP_BIT_OSC_PRI 7
`define ISP_BIT_NVM_PRI 4
`define ISP_BIT_LV_PRI  2
`define ISP_BIT_PWM_PRI 4
`define ISP_PRI2_MASK   8'h94
`define ISP_PRI3_MASK   8'h10
`define ISP_RST_PRI2    8'h94
`define ISP_RST_PRI3    8'h10
`define ISP_RST_PDIR    4'hf
`define ISP_TZ_MAX8     8'hff
`define ISP_TZ_MAX16    16'hffff
`endif

// [rtl/isp_pkg.sv]
package isp_pkg;
	// power state of the core as seen by the wake logic
	typedef enum logic [0:0] {
		ISP_RUN   = 1'b0,
		ISP_SLEEP = 1'b1
	} isp_pmode_t;
endpackage : isp_pkg

// [rtl/isp_top.sv]
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "isp_defines.svh"
module isp_top #(
	parameter int PC_W  = 21,
	parameter int DEPTH = 31
) (
	input  wire logic            clk_sys_i,
	input  wire logic            rst_i,
	input  wire logic            psel_i,
	input  wire logic            penable_i,
	input  wire logic            pwrite_i,
	input  wire logic [7:0]      paddr_i,
	input  wire logic [31:0]     pwdata_i,
	output logic      [31:0]     prdata_o,
	output logic                 pready_o,
	output logic                 pslverr_o,
	input  wire logic [3:0]      pins_i,
	input  wire logic            osc_fail_req_i,
	input  wire logic            nvm_write_req_i,
	input  wire logic            low_voltage_req_i,
	input  wire logic            pwm_tb_req_i,
	input  wire logic            irq_take_i,
	input  wire logic            irq_return_i,
	input  wire logic            fast_return_i,
	input  wire logic [PC_W-1:0] pc_i,
	input  wire logic [7:0]      working_register_i,
	input  wire logic [7:0]      status_i,
	input  wire logic [3:0]      bank_select_register_i,
	output logic                 irq_high_o,
	output logic                 irq_low_o,
	output logic                 wake_o,
	output logic                 wake_vector_o,
	output logic      [PC_W-1:0] ret_pc_o,
	output logic                 ret_valid_o,
	output logic                 stack_overflow_o,
	output logic      [7:0]      fast_working_o,
	output logic      [7:0]      fast_status_o,
	output logic      [3:0]      fast_bank_o,
	output logic                 fast_valid_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic                 global_irq_enable;
	logic                 low_irq_enable;
	logic                 timer_zero_enable;
	logic                 pin_change_enable;
	logic                 timer_zero_flag;
	logic                 pin_change_flag;
	logic                 timer_zero_priority;
	logic                 pin_change_priority;
	logic [3:0]           ext_pin_enable;
	logic [3:0]           ext_pin_flag;
	logic [3:0]           ext_edge_select;
	logic [3:1]           ext_pri;
	logic [7:0]           peripheral_priority_second;
	logic [7:0]           peripheral_priority_third;
	logic                 tz_mode16;
	logic                 tz_run;
	logic [15:0]          timer_zero_counter;
	logic [3:0]           pin_is_input;
	logic [3:0]           port_latch;
	logic [3:0]           pin_s1;
	logic [3:0]           pin_s2;
	logic [3:0]           pin_d;
	isp_pkg::isp_pmode_t  pmode;
	logic [PC_W-1:0]      stk [DEPTH];
	logic [5:0]           sp;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic        rd;
	logic [7:0]  wd;
	logic [31:0] rd_val;
	logic        hit;

	assign acc = psel_i & penable_i & pready_o;
	assign wr  = acc & pwrite_i;
	assign rd  = acc & ~pwrite_i;
	assign wd  = pwdata_i[7:0];

	// read mux; unimplemented bits come back as zero
	always_comb begin
		rd_val = 32'h0;
		hit    = 1'b1;
		case (paddr_i)
			`ISP_OFS_MAIN: rd_val[7:0] = {global_irq_enable, low_irq_enable,
				timer_zero_enable, ext_pin_enable[0], pin_change_enable,
				timer_zero_flag, ext_pin_flag[0], pin_change_flag};
			`ISP_OFS_SECOND: rd_val[7:0] = {1'b0, ext_edge_select,
				timer_zero_priority, ext_pri[3], pin_change_priority};
			`ISP_OFS_THIRD: rd_val[7:0] = {ext_pri[2], ext_pri[1],
				ext_pin_enable[3:1], ext_pin_flag[3:1]};
			`ISP_OFS_PRI2:  rd_val[7:0] = peripheral_priority_second; // R3
			`ISP_OFS_PRI3:  rd_val[7:0] = peripheral_priority_third;  // R3
			`ISP_OFS_TZCTL: rd_val[1:0] = {tz_run, tz_mode16};
			`ISP_OFS_TZCNT: rd_val[15:0] = timer_zero_counter;
			`ISP_OFS_PDIR:  rd_val[3:0] = pin_is_input;
			`ISP_OFS_PORT:  rd_val[3:0] = pin_s2;
			`ISP_OFS_PMODE: rd_val[0] = pmode;
			default: hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// apb answer
	// ------------------------------------------------------------
	// one wait state: data is captured in the cycle pready rises
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i & penable_i & ~pready_o;
			prdata_o  <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ? rd_val : 32'h0;
			pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
		end
	end

	// ------------------------------------------------------------
	// control bits
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			global_irq_enable   <= 1'b0;
			low_irq_enable      <= 1'b0;
			timer_zero_enable   <= 1'b0;
			pin_change_enable   <= 1'b0;
			ext_pin_enable      <= 4'h0;
			ext_edge_select     <= 4'hf;
			timer_zero_priority <= 1'b1;
			pin_change_priority <= 1'b1;
			ext_pri             <= 3'h7;
		end else if (wr) begin
			if (paddr_i == `ISP_OFS_MAIN) begin
				global_irq_enable <= wd[7];
				low_irq_enable    <= wd[6];
				timer_zero_enable <= wd[5];    // R14
				ext_pin_enable[0] <= wd[4];
				pin_change_enable <= wd[3];    // R16
			end
			if (paddr_i == `ISP_OFS_SECOND) begin
				ext_edge_select     <= wd[6:3];
				timer_zero_priority <= wd[2]; // R14
				ext_pri[3]          <= wd[1]; // R10
				pin_change_priority <= wd[0]; // R16
			end
			if (paddr_i == `ISP_OFS_THIRD) begin
				ext_pri[2]          <= wd[7]; // R10
				ext_pri[1]          <= wd[6]; // R10
				ext_pin_enable[3:1] <= wd[5:3];
			end
		end
	end

	// priority registers keep only their implemented bits
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			peripheral_priority_second <= `ISP_RST_PRI2; // R1
			peripheral_priority_third  <= `ISP_RST_PRI3; // R2
		end else if (wr) begin
			if (paddr_i == `ISP_OFS_PRI2)
				peripheral_priority_second <= wd & `ISP_PRI2_MASK; // R1 R3
			if (paddr_i == `ISP_OFS_PRI3)
				peripheral_priority_third <= wd & `ISP_PRI3_MASK;  // R2 R3
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	// no reset: the chain keeps tracking the pins, so a level held high
	// across reset is not mistaken for a fresh edge once reset ends
	always_ff @(posedge clk_sys_i) begin
		pin_s1 <= pins_i;
		pin_s2 <= pin_s1;
		pin_d  <= pin_s2;
	end

	logic [3:0] edge_hit;
	logic [3:0] flag_wr;
	logic [3:0] flag_wd;

	assign edge_hit = (ext_edge_select & pin_s2 & ~pin_d)   // R4
		| (~ext_edge_select & ~pin_s2 & pin_d);              // R4
	assign flag_wr  = {{3{wr & (paddr_i == `ISP_OFS_THIRD)}},
		wr & (paddr_i == `ISP_OFS_MAIN)};
	assign flag_wd  = {wd[2:0], wd[1]};

	// the edge wins over a clear written in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ext
			always_ff @(posedge clk_sys_i) begin
				if (rst_i)
					ext_pin_flag[gi] <= 1'b0;
				else if (edge_hit[gi])
					ext_pin_flag[gi] <= 1'b1; // R5 R6
				else if (flag_wr[gi])
					ext_pin_flag[gi] <= flag_wd[gi];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// pin change
	// ------------------------------------------------------------
	logic pc_mismatch;

	assign pc_mismatch = |((pin_s2 ^ port_latch) & pin_is_input); // R19 R20

	// a port read refreshes the reference, ending the mismatch
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			port_latch   <= pin_s2; // reference follows the pins, no change seen at reset end
			pin_is_input <= `ISP_RST_PDIR;
		end else begin
			if (rd && paddr_i == `ISP_OFS_PORT)
				port_latch <= pin_s2; // R19
			if (wr && paddr_i == `ISP_OFS_PDIR)
				pin_is_input <= wd[3:0]; // R20
		end
	end

	// a standing mismatch keeps setting the flag over any clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			pin_change_flag <= 1'b0;
		else if (pc_mismatch)
			pin_change_flag <= 1'b1; // R15 R19
		else if (wr && paddr_i == `ISP_OFS_MAIN)
			pin_change_flag <= wd[0];
	end

	// ------------------------------------------------------------
	// timer zero
	// ------------------------------------------------------------
	logic        tz_ovf;
	logic [15:0] next_count;

	assign tz_ovf = tz_run & (tz_mode16
		? (timer_zero_counter == `ISP_TZ_MAX16)        // R13
		: (timer_zero_counter[7:0] == `ISP_TZ_MAX8));  // R12
	// in 8-bit mode the high byte is left alone
	assign next_count = tz_mode16 ? timer_zero_counter + 16'h1
		: {timer_zero_counter[15:8], timer_zero_counter[7:0] + 8'h1};

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tz_mode16 <= 1'b0; // R12
			tz_run    <= 1'b0;
		end else if (wr && paddr_i == `ISP_OFS_TZCTL) begin
			tz_mode16 <= wd[0];
			tz_run    <= wd[1];
		end
	end

	// a software load takes precedence over counting
	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			timer_zero_counter <= 16'h0;
		else if (wr && paddr_i == `ISP_OFS_TZCNT)
			timer_zero_counter <= pwdata_i[15:0];
		else if (tz_run)
			timer_zero_counter <= next_count;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			timer_zero_flag <= 1'b0;
		else if (tz_ovf)
			timer_zero_flag <= 1'b1; // R12 R13
		else if (wr && paddr_i == `ISP_OFS_MAIN)
			timer_zero_flag <= wd[2];
	end

	// ------------------------------------------------------------
	// request routing
	// ------------------------------------------------------------
	logic [9:0] act;
	logic [9:0] pri;
	logic       hi_pend;
	logic       lo_pend;
	logic       ext_act;

	assign act = {osc_fail_req_i, nvm_write_req_i, low_voltage_req_i, pwm_tb_req_i,
		timer_zero_flag & timer_zero_enable,  // R14 R21
		pin_change_flag & pin_change_enable,  // R16 R21
		ext_pin_flag & ext_pin_enable};       // R6 R21
	assign pri = {peripheral_priority_second[`ISP_BIT_OSC_PRI],
		peripheral_priority_second[`ISP_BIT_NVM_PRI],
		peripheral_priority_second[`ISP_BIT_LV_PRI],
		peripheral_priority_third[`ISP_BIT_PWM_PRI],
		timer_zero_priority, pin_change_priority,
		ext_pri, 1'b1};                       // R10 R11
	assign hi_pend = |(act & pri);            // R21
	assign lo_pend = |(act & ~pri);           // R21
	assign ext_act = |act[3:0];

	// low level also needs the high enable, as the high level masks it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_high_o <= 1'b0;
			irq_low_o  <= 1'b0;
		end else begin
			irq_high_o <= hi_pend & global_irq_enable;
			irq_low_o  <= lo_pend & global_irq_enable & low_irq_enable;
		end
	end

	// ------------------------------------------------------------
	// sleep and wake
	// ------------------------------------------------------------
	logic wake_now;

	// flag and enable are taken as they stand, so a late enable over a set flag still wakes
	assign wake_now = (pmode == isp_pkg::ISP_SLEEP)
		& (ext_act | (pin_change_flag & pin_change_enable)); // R8

	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			pmode <= isp_pkg::ISP_RUN;
		else if (wake_now)
			pmode <= isp_pkg::ISP_RUN; // R8
		else if (wr && paddr_i == `ISP_OFS_PMODE && wd[0])
			pmode <= isp_pkg::ISP_SLEEP;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wake_o        <= 1'b0;
			wake_vector_o <= 1'b0;
		end else begin
			wake_o        <= wake_now;
			wake_vector_o <= wake_now & global_irq_enable; // R9
		end
	end

	// ------------------------------------------------------------
	// return stack
	// ------------------------------------------------------------
	logic push_ok;
	logic pop_ok;

	// a push onto a full stack is dropped and flagged, not wrapped
	assign push_ok = irq_take_i & (sp < 6'(DEPTH));
	assign pop_ok  = irq_return_i & ~irq_take_i & (sp != 6'h0);

	always_ff @(posedge clk_sys_i) begin
		if (push_ok)
			stk[5'(sp)] <= pc_i; // R17
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sp               <= 6'h0;
			stack_overflow_o <= 1'b0;
			ret_pc_o         <= '0;
			ret_valid_o      <= 1'b0;
		end else begin
			ret_valid_o <= pop_ok;
			if (push_ok)
				sp <= sp + 6'h1; // R17
			else if (pop_ok) begin
				sp       <= sp - 6'h1;
				ret_pc_o <= stk[5'(sp - 6'h1)];
			end
			if (irq_take_i && !push_ok)
				stack_overflow_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// fast shadow registers
	// ------------------------------------------------------------
	// single level: a nested take overwrites the earlier copy
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fast_working_o <= 8'h0;
			fast_status_o  <= 8'h0;
			fast_bank_o    <= 4'h0;
		end else if (irq_take_i) begin
			fast_working_o <= working_register_i;     // R18
			fast_status_o  <= status_i;               // R18
			fast_bank_o    <= bank_select_register_i; // R18
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			fast_valid_o <= 1'b0;
		else
			fast_valid_o <= pop_ok & fast_return_i;
	end

endmodule : isp_top

// [tb/isp_asserts.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module isp_checker (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        irq_return_i,
	input wire logic        fast_return_i,
	input wire logic        ret_valid_o,
	input wire logic        fast_valid_o,
	input wire logic        wake_o,
	input wire logic        wake_vector_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// exactly one wait state, then ready for one cycle only
	a_ready_one_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
		else $error("ready late");
	a_ready_single: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	a_unmapped_err: assert property (pready_o
		&& (paddr_i > 8'h24 || paddr_i[1:0] != 2'h0) |-> pslverr_o)
		else $error("no error on unmapped access");
	a_err_only_unmapped: assert property (pslverr_o
		|-> pready_o && (paddr_i > 8'h24 || paddr_i[1:0] != 2'h0))
		else $error("stray error");
	a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside ready");
	a_pri2_unused: assert property (pready_o && !pwrite_i && paddr_i == 8'h0c
		|-> (prdata_o & 32'hffffff6b) == 32'h0)
		else $error("second priority spare bit set");
	a_pri3_unused: assert property (pready_o && !pwrite_i && paddr_i == 8'h10
		|-> (prdata_o & 32'hffffffef) == 32'h0)
		else $error("third priority spare bit set");
	a_ret_after_pop: assert property (ret_valid_o |-> $past(irq_return_i))
		else $error("return address without pop");
	a_fast_restore: assert property (fast_valid_o |-> $past(irq_return_i && fast_return_i))
		else $error("shadow restore without fast return");
	a_vector_wake: assert property (wake_vector_o |-> wake_o)
		else $error("vector without wake");
endmodule : isp_checker

bind isp_top isp_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .irq_return_i(irq_return_i),
	.fast_return_i(fast_return_i), .ret_valid_o(ret_valid_o), .fast_valid_o(fast_valid_o),
	.wake_o(wake_o), .wake_vector_o(wake_vector_o));

// [tb/isp_core_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// core model: takes a pending request on command
// ----------------------------------------------------------------
module isp_core_model #(
	parameter logic [20:0] PC_BASE = 21'h000100
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        take_cmd_i,
	input  wire logic        ret_cmd_i,
	input  wire logic        slow_i,
	input  wire logic        fast_i,
	input  wire logic        irq_high_i,
	input  wire logic        irq_low_i,
	output logic             irq_take_o,
	output logic             irq_return_o,
	output logic             fast_return_o,
	output logic      [20:0] pc_o,
	output logic      [7:0]  working_register_o,
	output logic      [7:0]  status_o,
	output logic      [3:0]  bank_o
);
	logic       armed;
	logic [1:0] dly;
	logic [7:0] takes;
	// context follows the take count, so the bench can predict it
	assign pc_o = PC_BASE + {11'h0, takes, 2'b00};
	assign working_register_o = takes;
	assign status_o = ~takes;
	assign bank_o = takes[3:0];
	assign fast_return_o = fast_i;
	// vectors only while a request stands; slow mode waits three cycles
	always_ff @(posedge clk_sys_i) begin
		irq_take_o <= 1'b0;
		irq_return_o <= 1'b0;
		if (rst_i) begin
			armed <= 1'b0;
			dly <= 2'h0;
			takes <= 8'h00;
		end else if (take_cmd_i) begin
			armed <= 1'b1;
			dly <= slow_i ? 2'h3 : 2'h0;
		end else if (armed && (irq_high_i || irq_low_i)) begin
			if (dly != 2'h0) begin
				dly <= dly - 2'h1;
			end else begin
				armed <= 1'b0;
				irq_take_o <= 1'b1;
				takes <= takes + 8'h01;
			end
		end else if (ret_cmd_i) begin
			irq_return_o <= 1'b1;
		end
	end
endmodule : isp_core_model

// [tb/isp_top_tb.sv]
`timescale 1ns/100ps
module isp_top_tb;
	// ----------------------------------------------------------------
	// signals and tables
	// ----------------------------------------------------------------
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic er;} isp_row_t;
	localparam logic [20:0] PC_BASE = 21'h000100;
	logic        clk, rst, psel, penable, pwrite, take, ret, slow, fast, e;
	logic        pready, perr, ihi, ilo, wk, wkv, itk, irt, frt, rv, fv, sov;
	logic [7:0]  paddr, working_register, stat, fw, fs;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pins, preq, bank, fbank;
	logic [20:0] pc, rpc;
	int          failures = 0;
	int          checks_done = 0;
	int          cycles = 0;
	logic [7:0]  pa [4] = '{8'h0c, 8'h0c, 8'h0c, 8'h10};
	logic [7:0]  pv [4] = '{8'h14, 8'h84, 8'h90, 8'h00};
	logic [7:0]  pr [4] = '{8'h94, 8'h94, 8'h94, 8'h10};
	isp_row_t    rows [16] = '{
		'{0, 8'h0c, 0, 8'h94, 0}, '{0, 8'h10, 0, 8'h10, 0}, '{0, 8'h04, 0, 8'h7f, 0},
		'{0, 8'h08, 0, 8'hc0, 0}, '{0, 8'h00, 0, 8'h00, 0}, '{0, 8'h1c, 0, 8'h0f, 0},
		'{1, 8'h0c, 8'h00, 0, 0}, '{0, 8'h0c, 0, 8'h00, 0}, '{1, 8'h0c, 8'hff, 0, 0},
		'{0, 8'h0c, 0, 8'h94, 0}, '{1, 8'h10, 8'hef, 0, 0}, '{0, 8'h10, 0, 8'h00, 0},
		'{1, 8'h10, 8'hff, 0, 0}, '{0, 8'h10, 0, 8'h10, 0}, '{0, 8'h3c, 0, 8'h00, 1},
		'{1, 8'h3c, 8'hff, 0, 1}};

	isp_top #(.PC_W(21), .DEPTH(31)) dut (
		.clk_sys_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(perr), .pins_i(pins), .osc_fail_req_i(preq[0]), .nvm_write_req_i(preq[1]),
		.low_voltage_req_i(preq[2]), .pwm_tb_req_i(preq[3]), .irq_take_i(itk),
		.irq_return_i(irt), .fast_return_i(frt), .pc_i(pc), .working_register_i(working_register),
		.status_i(stat), .bank_select_register_i(bank), .irq_high_o(ihi), .irq_low_o(ilo),
		.wake_o(wk), .wake_vector_o(wkv), .ret_pc_o(rpc), .ret_valid_o(rv),
		.stack_overflow_o(sov), .fast_working_o(fw), .fast_status_o(fs), .fast_bank_o(fbank),
		.fast_valid_o(fv));
	isp_core_model #(.PC_BASE(PC_BASE)) u_core (.clk_sys_i(clk), .rst_i(rst),
		.take_cmd_i(take), .ret_cmd_i(ret), .slow_i(slow), .fast_i(fast), .irq_high_i(ihi),
		.irq_low_i(ilo), .irq_take_o(itk), .irq_return_o(irt), .fast_return_o(frt),
		.pc_o(pc), .working_register_o(working_register), .status_o(stat), .bank_o(bank));

	// clock and hang guard; the run needs well under 3000 cycles
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			failures++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// held until the edge that samples ready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no local limit: only the bench timeout ends a hung access
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, {24'h0, x}, r & {24'h0, m});
	endtask : rdc

	task automatic st(input int n);
		repeat (n) @(posedge clk);
	endtask : st

	task automatic core(input logic t, input logic s, input logic f);
		slow <= s;
		fast <= f;
		take <= t;
		ret <= !t;
		@(posedge clk);
		take <= 1'b0;
		ret <= 1'b0;
	endtask : core

	// a pulse is caught at the edge that ends its cycle
	task automatic catch_pulse(input logic sel);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((sel ? wk : rv) !== 1'b1 && n < 20);
		chk("pulse", 1, sel ? wk : rv);
	endtask : catch_pulse

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, take, ret, slow, fast} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pins = 4'h0;
		preq = 4'h0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
			chk("slverr", rows[i].er, e);
			if (!rows[i].w) chk("rdata", {24'h0, rows[i].x}, r);
		end
		wr(8'h00, 8'hc0);
		for (int i = 0; i < 4; i++) begin
			preq <= 4'h1 << i;
			st(4);
			chk("irq_high", 1, ihi);
			wr(pa[i], pv[i]);
			st(4);
			chk("irq_level", 2'b01, {ihi, ilo});
			wr(pa[i], pr[i]);
		end
		preq <= 4'h1;
		core(1'b1, 1'b0, 1'b0);
		st(8);
		core(1'b1, 1'b1, 1'b0);
		st(8);
		core(1'b0, 1'b0, 1'b1);
		catch_pulse(1'b0);
		chk("ret_pc", PC_BASE + 21'h8, rpc);
		chk("shadow", {8'h02, 8'hfd, 4'h2}, {fw, fs, fbank});
		chk("fast_valid", 1, fv);
		core(1'b0, 1'b0, 1'b0);
		catch_pulse(1'b0);
		chk("ret_pc", PC_BASE + 21'h4, rpc);
		chk("fast_valid", 0, fv);
		chk("overflow", 0, sov);
		preq <= 4'h0;
		wr(8'h00, 8'h90);
		pins <= 4'h1;
		st(8);
		chk("irq_high", 1, ihi);
		wr(8'h00, 8'h82);
		st(4);
		chk("irq_high", 0, ihi);
		rdc("ext0_flag", 8'h00, 8'h02, 8'h02);
		wr(8'h00, 8'h80);
		pins <= 4'h0;
		st(8);
		wr(8'h00, 8'h90);
		st(4);
		chk("irq_high", 0, ihi);
		wr(8'h04, 8'h6f);
		wr(8'h08, 8'h08);
		wr(8'h00, 8'hc0);
		pins <= 4'h2;
		st(8);
		chk("irq_low", 0, ilo);
		pins <= 4'h0;
		st(8);
		chk("irq_level", 2'b01, {ihi, ilo});
		rdc("ext1_flag", 8'h08, 8'h01, 8'h01);
		wr(8'h08, 8'h00);
		wr(8'h00, 8'h90);
		wr(8'h24, 8'h01);
		pins <= 4'h1;
		catch_pulse(1'b1);
		chk("wake_vector", 1, wkv);
		pins <= 4'h0;
		st(6);
		wr(8'h00, 8'h10);
		wr(8'h24, 8'h01);
		pins <= 4'h1;
		catch_pulse(1'b1);
		chk("wake_vector", 0, wkv);
		wr(8'h00, 8'ha0);
		wr(8'h18, 8'hf0);
		wr(8'h14, 8'h02);
		st(30);
		chk("irq_high", 1, ihi);
		rdc("tmr_flag", 8'h00, 8'h04, 8'h04);
		wr(8'h14, 8'h00);
		wr(8'h00, 8'ha0);
		wr(8'h18, 8'hf0);
		wr(8'h14, 8'h03);
		st(30);
		chk("irq_high", 0, ihi);
		wr(8'h14, 8'h00);
		wr(8'h00, 8'ha0);
		apb(1'b1, 8'h18, 32'h0000fff0);
		wr(8'h14, 8'h03);
		st(30);
		chk("irq_high", 1, ihi);
		wr(8'h14, 8'h00);
		wr(8'h00, 8'h80);
		rdc("port", 8'h20, 8'h0f, 8'h01);
		wr(8'h00, 8'h88);
		wr(8'h1c, 8'h0b);
		pins <= 4'h5;
		st(8);
		rdc("chg_flag", 8'h00, 8'h01, 8'h00);
		wr(8'h1c, 8'h0f);
		st(8);
		chk("irq_high", 1, ihi);
		wr(8'h00, 8'h88);
		st(4);
		rdc("chg_flag", 8'h00, 8'h01, 8'h01);
		rdc("port", 8'h20, 8'h0f, 8'h05);
		wr(8'h00, 8'h88);
		st(4);
		rdc("chg_flag", 8'h00, 8'h01, 8'h00);
		wr(8'h0c, 8'h00);
		rst <= 1'b1;
		st(2);
		rst <= 1'b0;
		@(posedge clk);
		rdc("pri2", 8'h0c, 8'hff, 8'h94);
		rdc("main", 8'h00, 8'hff, 8'h00);
		stop_test();
	end
endmodule : isp_top_tb
